// ==== core/multiband_gain_gating_defines.svh ====
`ifndef MULTIBAND_GAIN_GATING_DEFINES_SVH
`define MULTIBAND_GAIN_GATING_DEFINES_SVH

`define MB_BANDS          5
`define MB_LVL_W          8
`define MB_GR_W           6
`define MB_GR_MAX         63

`define MB_CLK_NS         8
`define MB_TICK_NS        1000000
`define MB_TICK_CYCLES    ((`MB_TICK_NS + `MB_CLK_NS - 1) / `MB_CLK_NS)
`define MB_TICK_W         17

`define MB_LEV_STEP_MASK   8'h07
`define MB_BAL_STEP_MASK   8'h1f
`define MB_CREEP_STEP_MASK 8'hff

`define MB_BAL_REF_DB     8'h0c
`define MB_LEV_REF_DB     8'h12
`define MB_COMP_REF_DB    8'h0a

`define MB_CTRL_OFS       8'h00
`define MB_DRIVE_OFS      8'h04
`define MB_GATE_OFS       8'h08
`define MB_DETAIL_OFS     8'h0c
`define MB_STATUS_OFS     8'h10
`define MB_GRBAL_OFS      8'h14
`define MB_GRLEV_OFS      8'h18
`define MB_GRCOMP_OFS     8'h1c

`define MB_CTRL_BAL_BIT   0
`define MB_CTRL_LEV_BIT   1
`define MB_CTRL_COMP_BIT  2
`define MB_CTRL_MODE_BIT  3
`define MB_GATE_DLY_LSB   16
`define MB_STAT_GATE_LSB  8
`define MB_GR_STRIDE      8

`define MB_THR_OFF        8'h00
`define MB_THR_MIN_DB     8'h14
`define MB_THR_MAX_DB     8'h46
`define MB_DLY_MIN_MS     9'h032
`define MB_DLY_MAX_MS     9'h1f4
`define MB_DETAIL_MAX     7'h64

`define MB_RST_DRIVE      4'h8
`define MB_RST_THR        8'h28
`define MB_RST_DLY        9'h064
`define MB_RST_DETAIL     7'h00

`endif

// ==== core/multiband_gain_gating_pkg.sv ====
`include "multiband_gain_gating_defines.svh"

package multiband_gain_gating_pkg;

  typedef logic [`MB_LVL_W-1:0] level_t;
  typedef logic [`MB_GR_W-1:0]  gr_t;
  typedef logic [`MB_GR_W:0]    grSum_t;

  typedef struct packed {
    logic                        valid;
    level_t [`MB_BANDS-1:0]      level;
  } bandLevels_t;

  typedef struct packed {
    logic comp;
    logic lev;
    logic bal;
  } stageEn_t;

  typedef enum logic {
    GATE_HOLD  = 1'b0,
    GATE_CREEP = 1'b1
  } gateMode_t;

  typedef struct packed {
    gr_t        bal;
    gr_t        lev;
    gr_t        comp;
    logic       gated;
    logic [8:0] gateMs;
  } band_t;

  typedef struct packed {
    logic [`MB_TICK_W-1:0]   tickCnt;
    logic                    msTick;
    logic [7:0]              msCnt;
    stageEn_t                en;
    gateMode_t               gmode;
    logic [3:0]              drive;
    level_t                  thresh;
    logic [8:0]              delayMs;
    logic [6:0]              detail;
    level_t [`MB_BANDS-1:0]  lvl;
    band_t [`MB_BANDS-1:0]   band;
    logic                    wrPend;
    logic [7:0]              wrAddr;
    logic                    rdPend;
    logic [7:0]              rdAddr;
    logic [31:0]             rdata;
    logic                    readyOut;
    logic                    resp;
    grSum_t [`MB_BANDS-1:0]  bandGr;
    logic [`MB_BANDS-1:0]    gateFlag;
    stageEn_t                active;
  } state_t;

endpackage

// ==== core/multiband_gain_gating.sv ====
// Summary of operation
// - all stages in: compressor gain never exceeds leveler gain, also during release.
// - balancer out, leveler in: compressor may only cut below leveler gain.
// - balancer and leveler out: compressor alone, no ceiling from another stage.
// - each stage has an enable; enabled means in path and indicator lit.
// - drive scales leveler and compressor reduction depth, never the balancer.
// - band below gate threshold becomes gated and its leveler and compressor action freezes.
// - gate delay 50 to 500 ms holds off freezing so partial release happens.
// - threshold selectable -20 to -70 dBFS, plus an off setting disabling gating.
// - hold mode keeps gain frozen; creep mode lets gain rise very slowly.
// - detail enhance is a percentage from off to 100 that relaxes processing.
// - per-band gate flag set while gated, clear while ungated.
// - five bands, lowest first, each band's state held independently.
// - balancer, leveler and compressor reduction reported per band for metering.
// - balancer acts first, ahead of leveler and compressor; gate detection sees the raw level.
`timescale 1ns/1ps
`default_nettype none

module multiband_gain_gating
  import multiband_gain_gating_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `MB_TICK_CYCLES
) (
  input  wire logic                    mclk,
  input  wire logic                    arst_n,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  input  wire bandLevels_t             bandIn,
  output var grSum_t [`MB_BANDS-1:0]   bandGr,
  output logic [`MB_BANDS-1:0]         gateFlag,
  output var stageEn_t                 stageActive
);

  state_t st_reg;
  state_t st_next;

  // dB below full scale above a reference, as reduction, saturated
  function automatic gr_t excess(input level_t ref_db, input level_t lvl);
    logic [7:0] d;
    d = 8'h00;
    if (lvl < ref_db) begin
      d = ref_db - lvl;
    end
    if (d > 8'(`MB_GR_MAX)) begin
      d = 8'(`MB_GR_MAX);
    end
    return d[`MB_GR_W-1:0];
  endfunction

  // drive weighting: drive 7 is unity, 15 is double
  function automatic gr_t scaleDrive(input gr_t x, input logic [3:0] drv);
    logic [10:0] p;
    p = 11'(x) * 11'({1'b0, drv} + 5'h01);
    p = p >> 3;
    if (p > 11'(`MB_GR_MAX)) begin
      p = 11'(`MB_GR_MAX);
    end
    return p[`MB_GR_W-1:0];
  endfunction

  function automatic gr_t stepToward(input gr_t cur, input gr_t tgt);
    gr_t r;
    r = cur;
    if (cur < tgt) begin
      r = cur + 1'b1;
    end else if (cur > tgt) begin
      r = cur - 1'b1;
    end
    return r;
  endfunction

  function automatic gr_t creepDown(input gr_t cur);
    return (cur != '0) ? gr_t'(cur - 1'b1) : cur;
  endfunction

  function automatic logic [31:0] packGr(input state_t s, input logic [1:0] which);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int i = 0; i < `MB_BANDS; i++) begin
      unique case (which)
        2'h0:    w[i*`MB_GR_STRIDE +: `MB_GR_W] = s.band[i].bal;
        2'h1:    w[i*`MB_GR_STRIDE +: `MB_GR_W] = s.band[i].lev;
        default: w[i*`MB_GR_STRIDE +: `MB_GR_W] = s.band[i].comp;
      endcase
    end
    return w;
  endfunction

  function automatic logic [31:0] readMux(input state_t s, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      `MB_CTRL_OFS: begin
        w[`MB_CTRL_BAL_BIT]  = s.en.bal;
        w[`MB_CTRL_LEV_BIT]  = s.en.lev;
        w[`MB_CTRL_COMP_BIT] = s.en.comp;
        w[`MB_CTRL_MODE_BIT] = s.gmode;
      end
      `MB_DRIVE_OFS:  w[3:0] = s.drive;
      `MB_GATE_OFS: begin
        w[7:0]                    = s.thresh;
        w[`MB_GATE_DLY_LSB +: 9]  = s.delayMs;
      end
      `MB_DETAIL_OFS: w[6:0] = s.detail;
      `MB_STATUS_OFS: begin
        w[2:0]                              = s.active;
        w[`MB_STAT_GATE_LSB +: `MB_BANDS]   = s.gateFlag;
      end
      `MB_GRBAL_OFS:  w = packGr(s, 2'h0);
      `MB_GRLEV_OFS:  w = packGr(s, 2'h1);
      `MB_GRCOMP_OFS: w = packGr(s, 2'h2);
      default:        w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // unmapped space folds onto an unused offset, so reads give 0 and writes drop
  function automatic logic [7:0] wordAddr(input logic [31:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'h0};
    if (a[31:8] != '0) begin
      w = 8'hff;
    end
    return w;
  endfunction

  always_comb begin
    logic       addrPhase;
    logic       balStep;
    logic       levStep;
    logic       creepStep;
    logic       creepNow;
    logic       below;
    logic       frozen;
    logic [8:0] sumIn;
    level_t     stageIn;
    gr_t        levTgt;
    gr_t        compTgt;
    logic [12:0] relaxed;
    logic [7:0] v8;
    logic [8:0] v9;
    logic [6:0] v7;
    addrPhase = 1'b0;
    balStep   = 1'b0;
    levStep   = 1'b0;
    creepStep = 1'b0;
    creepNow  = 1'b0;
    below     = 1'b0;
    frozen    = 1'b0;
    sumIn     = 9'h000;
    stageIn   = '0;
    levTgt    = '0;
    compTgt   = '0;
    relaxed   = 13'h0000;
    v8        = 8'h00;
    v9        = 9'h000;
    v7        = 7'h00;
    st_next   = st_reg;

    // one cycle ms enable, slower stage rates derived from it
    st_next.msTick = 1'b0;
    if (st_reg.tickCnt == `MB_TICK_W'(TICK_CYCLES - 1)) begin
      st_next.tickCnt = '0;
      st_next.msTick  = 1'b1;
    end else begin
      st_next.tickCnt = st_reg.tickCnt + 1'b1;
    end
    if (st_reg.msTick) begin
      st_next.msCnt = st_reg.msCnt + 8'h01;
    end
    balStep   = st_reg.msTick && ((st_reg.msCnt & `MB_BAL_STEP_MASK) == 8'h00);
    levStep   = st_reg.msTick && ((st_reg.msCnt & `MB_LEV_STEP_MASK) == 8'h00);
    creepStep = st_reg.msTick && ((st_reg.msCnt & `MB_CREEP_STEP_MASK) == 8'h00);
    // creep only in creep mode, hold keeps a frozen gain exact
    creepNow  = creepStep && (st_reg.gmode == GATE_CREEP);

    if (bandIn.valid) begin
      st_next.lvl = bandIn.level;
    end

    for (int i = 0; i < `MB_BANDS; i++) begin
      // balancer sees raw input only, drive deliberately not applied
      if (!st_reg.en.bal) begin
        st_next.band[i].bal = '0;
      end else if (balStep) begin
        st_next.band[i].bal = stepToward(st_reg.band[i].bal,
                                         excess(`MB_BAL_REF_DB, st_reg.lvl[i]));
      end

      // later stages see the level after balancer reduction
      sumIn = {1'b0, st_reg.lvl[i]} + 9'(st_reg.band[i].bal);
      stageIn = sumIn[8] ? 8'hff : sumIn[7:0];

      // gate detection on incoming band level
      // a larger level number is quieter, so below threshold means greater
      below = (st_reg.thresh != `MB_THR_OFF) && (st_reg.lvl[i] > st_reg.thresh);
      if (!below) begin
        st_next.band[i].gateMs = 9'h000;
        st_next.band[i].gated  = 1'b0;
      end else if (st_reg.band[i].gateMs >= st_reg.delayMs) begin
        st_next.band[i].gated = 1'b1;
      end else if (st_reg.msTick) begin
        st_next.band[i].gateMs = st_reg.band[i].gateMs + 9'h001;
      end

      frozen = st_reg.band[i].gated;

      levTgt  = scaleDrive(excess(`MB_LEV_REF_DB, stageIn), st_reg.drive);
      compTgt = scaleDrive(excess(`MB_COMP_REF_DB, stageIn), st_reg.drive);
      // detail enhance backs compressor depth off by its percentage
      // leveler depth stays as driven, so detail only relaxes the fast stage
      relaxed = 13'(compTgt) * 13'(7'(`MB_DETAIL_MAX) - st_reg.detail);
      relaxed = relaxed / 13'(`MB_DETAIL_MAX);
      compTgt = relaxed[`MB_GR_W-1:0];

      if (!st_reg.en.lev) begin
        st_next.band[i].lev = '0;
      end else if (frozen) begin
        if (creepNow) begin
          st_next.band[i].lev = creepDown(st_reg.band[i].lev);
        end
      end else if (levStep) begin
        st_next.band[i].lev = stepToward(st_reg.band[i].lev, levTgt);
      end

      if (!st_reg.en.comp) begin
        st_next.band[i].comp = '0;
      end else if (frozen) begin
        if (creepNow) begin
          st_next.band[i].comp = creepDown(st_reg.band[i].comp);
        end
      end else if (st_reg.msTick) begin
        st_next.band[i].comp = stepToward(st_reg.band[i].comp, compTgt);
      end
      // ceiling applied after release step so a releasing band never overshoots
      if (st_reg.en.comp && st_reg.en.lev &&
          st_next.band[i].comp < st_next.band[i].lev) begin
        st_next.band[i].comp = st_next.band[i].lev;
      end
      // leveler out: compressor runs free, no ceiling

      st_next.bandGr[i] = grSum_t'(st_next.band[i].bal) +
                          grSum_t'(st_reg.en.comp ? st_next.band[i].comp
                                                  : st_next.band[i].lev);
      st_next.gateFlag[i] = st_next.band[i].gated;
    end
    st_next.active = st_reg.en;

    // ahb-lite slave: zero wait writes, one wait state on reads
    addrPhase = hsel && htrans[1] && hready;
    st_next.resp = 1'b0;
    // writes land in the data phase, while hwdata stands
    if (st_reg.wrPend) begin
      st_next.wrPend = 1'b0;
      unique case (st_reg.wrAddr)
        `MB_CTRL_OFS: begin
          st_next.en.bal  = hwdata[`MB_CTRL_BAL_BIT];
          st_next.en.lev  = hwdata[`MB_CTRL_LEV_BIT];
          st_next.en.comp = hwdata[`MB_CTRL_COMP_BIT];
          st_next.gmode   = gateMode_t'(hwdata[`MB_CTRL_MODE_BIT]);
        end
        `MB_DRIVE_OFS: st_next.drive = hwdata[3:0];
        `MB_GATE_OFS: begin
          v8 = hwdata[7:0];
          if (v8 != `MB_THR_OFF && v8 < `MB_THR_MIN_DB) begin
            v8 = `MB_THR_MIN_DB;
          end else if (v8 > `MB_THR_MAX_DB) begin
            v8 = `MB_THR_MAX_DB;
          end
          st_next.thresh = v8;
          v9 = hwdata[`MB_GATE_DLY_LSB +: 9];
          if (v9 < `MB_DLY_MIN_MS) begin
            v9 = `MB_DLY_MIN_MS;
          end else if (v9 > `MB_DLY_MAX_MS) begin
            v9 = `MB_DLY_MAX_MS;
          end
          st_next.delayMs = v9;
        end
        `MB_DETAIL_OFS: begin
          v7 = hwdata[6:0];
          if (hwdata[31:7] != '0 || v7 > `MB_DETAIL_MAX) begin
            v7 = `MB_DETAIL_MAX;
          end
          st_next.detail = v7;
        end
        default: ;
      endcase
    end
    if (st_reg.rdPend) begin
      st_next.rdPend   = 1'b0;
      st_next.rdata    = readMux(st_reg, st_reg.rdAddr);
      st_next.readyOut = 1'b1;
    end
    if (addrPhase) begin
      // sub-word writes are ignored, only whole words update registers
      if (hwrite) begin
        st_next.wrPend = (hsize == 3'h2);
        st_next.wrAddr = wordAddr(haddr);
      end else begin
        st_next.rdPend   = 1'b1;
        st_next.rdAddr   = wordAddr(haddr);
        st_next.readyOut = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg          <= '0;
      st_reg.en       <= '{comp: 1'b1, lev: 1'b1, bal: 1'b1};
      st_reg.gmode    <= GATE_HOLD;
      st_reg.drive    <= `MB_RST_DRIVE;
      st_reg.thresh   <= `MB_RST_THR;
      st_reg.delayMs  <= `MB_RST_DLY;
      st_reg.detail   <= `MB_RST_DETAIL;
      st_reg.lvl      <= '1;
      st_reg.readyOut <= 1'b1;
      st_reg.active   <= '{comp: 1'b1, lev: 1'b1, bal: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign hreadyout   = st_reg.readyOut;
  assign hresp       = st_reg.resp;
  assign hrdata      = st_reg.rdata;
  assign bandGr      = st_reg.bandGr;
  assign gateFlag    = st_reg.gateFlag;
  assign stageActive = st_reg.active;

endmodule

`default_nettype wire

// ==== dv/multiband_gain_gating_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "multiband_gain_gating_defines.svh"

module multiband_gain_gating_asserts
  import multiband_gain_gating_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `MB_TICK_CYCLES
) (
  input wire logic                   mclk,
  input wire logic                   arst_n,
  input wire logic                   hsel,
  input wire logic [31:0]            haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic [2:0]             hsize,
  input wire logic [31:0]            hwdata,
  input wire logic                   hready,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire bandLevels_t            bandIn,
  input wire grSum_t [`MB_BANDS-1:0] bandGr,
  input wire logic [`MB_BANDS-1:0]   gateFlag,
  input wire stageEn_t               stageActive
);
  // enable and threshold shadows rebuilt from bus traffic, clamped like the core
  logic                   wPend;
  logic [5:0]             wIdx;
  stageEn_t               ctrlSh;
  level_t                 thrSh;
  level_t [`MB_BANDS-1:0] lvlSh;
  logic                   take;
  assign take = hsel && htrans[1] && hready;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wPend <= 1'b0;
      wIdx <= 6'h00;
      ctrlSh <= 3'h7;
      thrSh <= 8'h28;
      lvlSh <= '1;
    end else begin
      if (hready) begin
        wPend <= take && hwrite && hsize == 3'h2 && haddr[31:8] == 24'h0;
        wIdx <= haddr[7:2];
      end
      if (wPend && hready && wIdx == 6'h00) begin
        ctrlSh <= hwdata[2:0];
      end
      if (wPend && hready && wIdx == 6'h02) begin
        thrSh <= (hwdata[7:0] == 8'h00) ? 8'h00 : (hwdata[7:0] < 8'h14) ? 8'h14 :
                 (hwdata[7:0] > 8'h46) ? 8'h46 : hwdata[7:0];
      end
      if (bandIn.valid) begin
        lvlSh <= bandIn.level;
      end
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_respOkay; hresp == 1'b0; endproperty
  a_respOkay: assert property (p_respOkay) else $error("response not okay");
  property p_readWait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_readWait: assert property (p_readWait) else $error("read wait not one cycle");
  property p_writeNoWait; take && hwrite |=> hreadyout; endproperty
  a_writeNoWait: assert property (p_writeNoWait) else $error("write stalled");
  property p_stageFollow; stageActive == $past(ctrlSh); endproperty
  a_stageFollow: assert property (p_stageFollow) else $error("stage lamp wrong");
  property p_idleZero; (stageActive == 3'h0) [*4] |-> bandGr == '0; endproperty
  a_idleZero: assert property (p_idleZero) else $error("bypassed but reducing");
  property p_gateOff; (thrSh == 8'h00) [*4] |-> gateFlag == 5'h00; endproperty
  a_gateOff: assert property (p_gateOff) else $error("gated while gate off");
  for (genvar i = 0; i < `MB_BANDS; i++) begin : g_band
    property p_ungate; (lvlSh[i] <= thrSh) [*4] |-> !gateFlag[i]; endproperty
    a_ungate: assert property (p_ungate) else $error("loud band still gated");
    property p_gateCause;
      $rose(gateFlag[i]) |-> $past(lvlSh[i] > thrSh && thrSh != 8'h00, 2);
    endproperty
    a_gateCause: assert property (p_gateCause) else $error("gate without cause");
  end
  cover property (gateFlag == 5'h1f);
  cover property (take && !hwrite);
  cover property (stageActive == 3'h0);
endmodule

bind multiband_gain_gating multiband_gain_gating_asserts #(.TICK_CYCLES(TICK_CYCLES)) watch (
  .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .bandIn(bandIn), .bandGr(bandGr),
  .gateFlag(gateFlag), .stageActive(stageActive)
);
`default_nettype wire

// ==== dv/band_source_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "multiband_gain_gating_defines.svh"

module band_source_model
  import multiband_gain_gating_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   arst_n,
  input  wire level_t [`MB_BANDS-1:0] target,
  input  wire logic [3:0]             gap,
  output bandLevels_t                 levels
);
  logic [3:0] cnt;

  // between strobes the bus carries inverted junk, so the core must latch on valid only
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 4'h0;
      levels <= '0;
    end else if (cnt >= gap) begin
      cnt <= 4'h0;
      levels <= {1'b1, target};
    end else begin
      cnt <= cnt + 4'h1;
      levels <= {1'b0, ~levels.level};
    end
  end
endmodule
`default_nettype wire

// ==== dv/multiband_gain_gating_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "multiband_gain_gating_defines.svh"

module multiband_gain_gating_bench
  import multiband_gain_gating_pkg::*;
;
  localparam int TC = 8;
  logic                        mclk = 1'b0;
  logic                        arst_n;
  logic                        hsel;
  logic                        hwrite;
  logic [1:0]                  htrans;
  logic [2:0]                  hsize;
  logic [31:0]                 haddr;
  logic [31:0]                 hwdata;
  logic [31:0]                 seed;
  logic [31:0]                 vb;
  logic [31:0]                 vl;
  logic [31:0]                 vc;
  level_t [`MB_BANDS-1:0]      target;
  logic [3:0]                  gap;
  logic                        hreadyout;
  logic [31:0]                 hrdata;
  bandLevels_t                 bandIn;
  grSum_t [`MB_BANDS-1:0]      bandGr;
  logic [4:0]                  gateFlag;
  stageEn_t                    stageActive;
  int                          failCount;
  int                          numChecks;
  logic [7:0]                  thrIn [4] = '{8'h05, 8'h50, 8'h46, 8'h00};
  logic [8:0]                  dlyIn [4] = '{9'h00a, 9'h1ff, 9'h032, 9'h1f4};
  logic [3:0]                  modes [3] = '{4'h4, 4'h6, 4'h7};

  always #4 mclk = ~mclk;

  multiband_gain_gating #(.TICK_CYCLES(TC)) dut (
    .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .bandIn(bandIn),
    .bandGr(bandGr), .gateFlag(gateFlag), .stageActive(stageActive)
  );
  band_source_model src (
    .mclk(mclk), .arst_n(arst_n), .target(target), .gap(gap), .levels(bandIn)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] expThr(input logic [7:0] t);
    return (t == 8'h00) ? 8'h00 : (t < 8'h14) ? 8'h14 : (t > 8'h46) ? 8'h46 : t;
  endfunction
  function automatic logic [8:0] expDly(input logic [8:0] d);
    return (d < 9'h032) ? 9'h032 : (d > 9'h1f4) ? 9'h1f4 : d;
  endfunction
  function automatic logic [5:0] fld(input logic [31:0] d, input int i);
    return d[8*i +: 6];
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stopTest();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // the slave decides the wait; the watchdog ends a wait that never finishes
  task automatic waitReady();
    do begin
      @(posedge mclk);
    end while (hreadyout !== 1'b1);
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    waitReady();
    htrans <= 2'b00;
    hwdata <= wd;
    waitReady();
    d = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rdChk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(what, d, exp);
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    failCount++;
    stopTest();
  end

  initial begin
    arst_n = 1'b0;
    hsel = 1'b1;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    seed = 32'h7beae3c1;
    target = '1;
    gap = 4'h0;
    failCount = 0;
    numChecks = 0;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    rdChk("ctrl", 32'h00, 32'h7);
    rdChk("drive", 32'h04, 32'h8);
    rdChk("gate", 32'h08, 32'h0064_0028);
    rdChk("detail", 32'h0c, 32'h0);
    rdChk("status", 32'h10, 32'h7);
    rdChk("unmapped", 32'h100, 32'h0);
    $display("reset values done");
    for (int k = 0; k < 4; k++) begin
      wr(32'h08, {7'h0, dlyIn[k], 8'h0, thrIn[k]});
      rdChk("gate", 32'h08, {7'h0, expDly(dlyIn[k]), 8'h0, expThr(thrIn[k])});
    end
    wr(32'h0c, 32'h78);
    rdChk("detail", 32'h0c, 32'h64);
    wr(32'h0c, 32'h0);
    repeat (3) begin
      seed = lfsr(seed);
      wr(32'h04, seed);
      rdChk("drive", 32'h04, {28'h0, seed[3:0]});
    end
    $display("register fields done");
    for (int c = 0; c < 8; c++) begin
      wr(32'h00, c);
      rdChk("status", 32'h10, c);
      chk("lamps", stageActive, c);
    end
    $display("stage enables done");
    seed = lfsr(seed);
    gap <= {2'b00, seed[1:0]};
    target <= '0;
    wr(32'h04, 32'hf);
    // drive 15 doubles the compressor depth, half detail halves it again
    wr(32'h0c, 32'h32);
    wr(32'h00, 32'h4);
    repeat (100 * TC) @(posedge mclk);
    bus(1'b0, 32'h1c, 32'h0, vc);
    for (int i = 0; i < 5; i++) begin
      chk("detail relax", fld(vc, i), 32'(`MB_COMP_REF_DB));
    end
    wr(32'h0c, 32'h0);
    $display("detail enhance done");
    foreach (modes[m]) begin
      wr(32'h00, modes[m]);
      repeat (500 * TC) @(posedge mclk);
      bus(1'b0, 32'h14, 32'h0, vb);
      bus(1'b0, 32'h18, 32'h0, vl);
      bus(1'b0, 32'h1c, 32'h0, vc);
      for (int i = 0; i < 5; i++) begin
        chk("comp vs leveler", 32'(fld(vc, i) >= fld(vl, i)), 32'h1);
        chk("total", bandGr[i], fld(vb, i) + fld(vc, i));
        if (modes[m] != 4'h7) chk("balancer out", fld(vb, i), 6'h0);
        if (modes[m] == 4'h4) chk("leveler out", fld(vl, i), 6'h0);
        if (modes[m] == 4'h4) begin
          chk("comp alone", fld(vc, i), 32'(2 * `MB_COMP_REF_DB));
        end
      end
    end
    $display("stage modes done");
    wr(32'h08, 32'h0032_0028);
    target <= {5{8'h3c}};
    repeat (40 * TC) @(posedge mclk);
    chk("gate delayed", gateFlag, 5'h00);
    repeat (20 * TC) @(posedge mclk);
    chk("gate flags", gateFlag, 5'h1f);
    rdChk("status", 32'h10, 32'h1f07);
    bus(1'b0, 32'h18, 32'h0, vl);
    repeat (100 * TC) @(posedge mclk);
    rdChk("hold", 32'h18, vl);
    wr(32'h00, 32'hf);
    repeat (600 * TC) @(posedge mclk);
    bus(1'b0, 32'h18, 32'h0, vc);
    chk("creep", 32'(fld(vc, 0) < fld(vl, 0)), 32'h1);
    seed = lfsr(seed);
    target[2] <= seed[7:0] & 8'h1f;
    repeat (12) @(posedge mclk);
    chk("ungate", gateFlag, 5'h1b);
    wr(32'h08, 32'h0032_0000);
    repeat (4) @(posedge mclk);
    chk("gate off", gateFlag, 5'h00);
    $display("gating done");
    stopTest();
  end
endmodule
`default_nettype wire
